// ---- can_bus_node.sv ----
// partner: far-side bus node producing frame, acknowledge and receiver levels
`timescale 1ns/1ps
module can_bus_node (
    input  wire logic clk,
    input  wire logic frameGo,
    input  wire logic ackGo,
    input  wire logic rxLevel,
    input  wire logic syncLevel,
    output logic      frameOk,
    output logic      ackDone,
    output logic      rxActive,
    output logic      synced
);
    always_ff @(posedge clk) begin
        frameOk  <= frameGo;
        ackDone  <= ackGo;
        rxActive <= rxLevel;
        synced   <= syncLevel;
    end
endmodule : can_bus_node

// ---- can_control_zero.sv ----
// module: control register 0 with status bits, timestamp timer, init handshake and interrupt
//
// Function
// - while init mode is active, register held reset except wake, sleep, init bits
// - stop in wait, timer enable, frame flag writes only with init request and acknowledge low; wake, sleep anytime; init request clears after acknowledge
// - received frame flag sets on every valid received frame outside init mode
// - received frame flag stays set until reset, init mode or a written one
// - receiver active bit mirrors the receiver front end
// - stop in wait gates the bus interface clock during wait mode
// - synchronized bit is read only and follows the bus sync state
// - timer enable starts a sixteen bit counter at bit rate
// - on acknowledge the timestamp is written to the top buffer bytes
// - counter clears when disabled; timer enable low during init mode
// - init acknowledge confirms init mode after init request
// - transmit pin forced recessive in wait with stop in wait, or stop
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module can_control_zero #(
    parameter logic [15:0] BIT_DIV = can_ctl0_pkg::BIT_DIV_RESET
) (
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire can_ctl0_pkg::reg_req_t regReq,
    output logic [7:0]                  regRdata,
    input  wire can_ctl0_pkg::link_in_t linkIn,
    output logic                        transmitPin,
    output logic                        busClockEnable,
    output logic                        stampWrite,
    output logic [3:0]                  stampByteHi,
    output logic [15:0]                 stampValue,
    output logic                        irq
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rstSync;
    logic       rstN;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync <= 2'b00;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstN = rstSync[1];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        rxFrame;
        logic        stopWait;
        logic        timerEn;
        logic        wakeupEn;
        logic        sleepReq;
        logic        initReq;
        logic        initAck;
        logic        rxActive;
        logic        synced;
        logic [15:0] divCount;
        logic [15:0] stampCount;
        logic [15:0] stampLast;
        logic [2:0]  irqStat;
        logic [2:0]  irqMask;
        logic [7:0]  rdata;
        logic        txPin;
        logic        busClkEn;
        logic        stampWr;
        logic        irqOut;
    } state_t;

    localparam state_t STATE_RESET = '{
        rxFrame:    can_ctl0_pkg::CTL0_RESET[can_ctl0_pkg::RX_FRAME_BIT],
        stopWait:   can_ctl0_pkg::CTL0_RESET[can_ctl0_pkg::STOP_WAIT_BIT],
        timerEn:    can_ctl0_pkg::CTL0_RESET[can_ctl0_pkg::TIMER_EN_BIT],
        wakeupEn:   can_ctl0_pkg::CTL0_RESET[can_ctl0_pkg::WAKEUP_EN_BIT],
        sleepReq:   can_ctl0_pkg::CTL0_RESET[can_ctl0_pkg::SLEEP_REQ_BIT],
        initReq:    can_ctl0_pkg::CTL0_RESET[can_ctl0_pkg::INIT_REQ_BIT],
        initAck:    1'b0,
        rxActive:   1'b0,
        synced:     1'b0,
        divCount:   can_ctl0_pkg::COUNT_RESET,
        stampCount: can_ctl0_pkg::COUNT_RESET,
        stampLast:  can_ctl0_pkg::COUNT_RESET,
        irqStat:    can_ctl0_pkg::IRQ_RESET,
        irqMask:    can_ctl0_pkg::IRQ_RESET,
        rdata:      8'h00,
        txPin:      1'b1,
        busClkEn:   1'b1,
        stampWr:    1'b0,
        irqOut:     1'b0
    };

    state_t st;
    state_t next_st;

    logic       initMode;
    logic       busWr;
    logic       busRd;
    logic [7:0] ctl0View;
    logic       bitTick;
    logic       frameEvt;
    logic       initEvt;
    logic       stampEvt;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st  = st;
        initMode = st.initReq && st.initAck;
        next_st.busClkEn = !(linkIn.waitMode && st.stopWait);
        busWr    = regReq.wr && next_st.busClkEn;
        busRd    = regReq.rd && next_st.busClkEn;
        bitTick  = (st.divCount == BIT_DIV);
        frameEvt = linkIn.frameOk && !initMode;
        initEvt  = st.initReq && !st.initAck;
        stampEvt = linkIn.ackDone && st.timerEn;

        ctl0View = 8'h00;
        ctl0View[can_ctl0_pkg::RX_FRAME_BIT]  = st.rxFrame;
        ctl0View[can_ctl0_pkg::RX_ACTIVE_BIT] = st.rxActive;
        ctl0View[can_ctl0_pkg::STOP_WAIT_BIT] = st.stopWait;
        ctl0View[can_ctl0_pkg::SYNC_BIT]      = st.synced;
        ctl0View[can_ctl0_pkg::TIMER_EN_BIT]  = st.timerEn;
        ctl0View[can_ctl0_pkg::WAKEUP_EN_BIT] = st.wakeupEn;
        ctl0View[can_ctl0_pkg::SLEEP_REQ_BIT] = st.sleepReq;
        ctl0View[can_ctl0_pkg::INIT_REQ_BIT]  = st.initReq;

        next_st.rxActive = linkIn.rxActive && !initMode;
        next_st.synced   = linkIn.synced && !initMode;
        next_st.initAck  = st.initReq;

        if (busWr && regReq.addr == can_ctl0_pkg::CTL0_OFFSET) begin
            // init request clears only after acknowledge
            if (regReq.wdata[can_ctl0_pkg::INIT_REQ_BIT] || st.initAck) begin
                next_st.initReq = regReq.wdata[can_ctl0_pkg::INIT_REQ_BIT];
            end
            next_st.wakeupEn = regReq.wdata[can_ctl0_pkg::WAKEUP_EN_BIT];
            next_st.sleepReq = regReq.wdata[can_ctl0_pkg::SLEEP_REQ_BIT];
            if (!st.initReq && !st.initAck) begin
                next_st.stopWait = regReq.wdata[can_ctl0_pkg::STOP_WAIT_BIT];
                next_st.timerEn  = regReq.wdata[can_ctl0_pkg::TIMER_EN_BIT];
                if (regReq.wdata[can_ctl0_pkg::RX_FRAME_BIT]) begin
                    next_st.rxFrame = 1'b0;
                end
            end
        end else if (busWr && regReq.addr == can_ctl0_pkg::IRQ_MASK_OFFSET) begin
            next_st.irqMask = regReq.wdata[2:0];
        end

        if (frameEvt) begin
            next_st.rxFrame = 1'b1;
        end

        if (initMode) begin
            next_st.rxFrame  = can_ctl0_pkg::CTL0_RESET[can_ctl0_pkg::RX_FRAME_BIT];
            next_st.stopWait = can_ctl0_pkg::CTL0_RESET[can_ctl0_pkg::STOP_WAIT_BIT];
            next_st.timerEn  = 1'b0;
        end

        if (!st.timerEn) begin
            next_st.divCount   = can_ctl0_pkg::COUNT_RESET;
            next_st.stampCount = can_ctl0_pkg::COUNT_RESET;
        end else if (bitTick) begin
            next_st.divCount   = can_ctl0_pkg::COUNT_RESET;
            next_st.stampCount = st.stampCount + 16'h0001;
        end else begin
            next_st.divCount   = st.divCount + 16'h0001;
        end

        next_st.stampWr = stampEvt;
        if (stampEvt) begin
            next_st.stampLast = st.stampCount;
        end

        if (linkIn.stopMode || (linkIn.waitMode && st.stopWait) || st.initReq) begin
            next_st.txPin = 1'b1;
        end else begin
            next_st.txPin = linkIn.txBit;
        end

        // status read clears, new events win
        if (busRd && regReq.addr == can_ctl0_pkg::IRQ_STAT_OFFSET) begin
            next_st.irqStat = can_ctl0_pkg::IRQ_RESET;
        end
        if (frameEvt) begin
            next_st.irqStat[can_ctl0_pkg::IRQ_FRAME_BIT] = 1'b1;
        end
        if (initEvt) begin
            next_st.irqStat[can_ctl0_pkg::IRQ_INIT_BIT] = 1'b1;
        end
        if (stampEvt) begin
            next_st.irqStat[can_ctl0_pkg::IRQ_STAMP_BIT] = 1'b1;
        end
        next_st.irqOut = |(next_st.irqStat & next_st.irqMask);

        // read data, one cycle later
        next_st.rdata = 8'h00;
        if (busRd) begin
            if (regReq.addr == can_ctl0_pkg::CTL0_OFFSET) begin
                next_st.rdata = ctl0View;
            end else if (regReq.addr == can_ctl0_pkg::CTL1_OFFSET) begin
                next_st.rdata[can_ctl0_pkg::INIT_ACK_BIT] = st.initAck;
            end else if (regReq.addr == can_ctl0_pkg::IRQ_STAT_OFFSET) begin
                next_st.rdata = {5'h00, st.irqStat};
            end else if (regReq.addr == can_ctl0_pkg::IRQ_MASK_OFFSET) begin
                next_st.rdata = {5'h00, st.irqMask};
            end else if (regReq.addr == can_ctl0_pkg::STAMP_LO_OFFSET) begin
                next_st.rdata = st.stampLast[7:0];
            end else if (regReq.addr == can_ctl0_pkg::STAMP_HI_OFFSET) begin
                next_st.rdata = st.stampLast[15:8];
            end else if (regReq.addr == can_ctl0_pkg::COUNT_LO_OFFSET) begin
                next_st.rdata = st.stampCount[7:0];
            end else if (regReq.addr == can_ctl0_pkg::COUNT_HI_OFFSET) begin
                next_st.rdata = st.stampCount[15:8];
            end else begin
                next_st.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign regRdata       = st.rdata;
    assign transmitPin    = st.txPin;
    assign busClockEnable = st.busClkEn;
    assign stampWrite     = st.stampWr;
    assign stampByteHi    = can_ctl0_pkg::STAMP_BYTE_HI;
    assign stampValue     = st.stampLast;
    assign irq            = st.irqOut;

endmodule : can_control_zero

// ---- can_control_zero_bench.sv ----
// testbench: register, status, interrupt, timer and low-power checks
`timescale 1ns/1ps
module can_control_zero_bench;
    logic clk = 1'b0, arst_n = 1'b0, rdSeen = 1'b0, rx, sy, irq;
    logic frameGo = 0, ackGo = 0, rxLevel = 0, syncLevel = 0, waitMode = 0, stopMode = 0;
    logic txBit = 0, fOk, aDone, rxA, syn, transmitPin, busClockEnable, stampWrite;
    logic [7:0] regRdata, expQ[$];
    logic [3:0] stampByteHi;
    logic [15:0] stampValue;
    can_ctl0_pkg::reg_req_t regReq = '0;
    can_ctl0_pkg::link_in_t linkIn;
    int nErrors = 0, compares = 0;
    always #2 clk = ~clk;
    assign linkIn = {fOk, rxA, syn, aDone, waitMode, stopMode, txBit};
    can_control_zero #(.BIT_DIV(16'h0003)) u_can_control_zero (
        .clk(clk), .arst_n(arst_n), .regReq(regReq), .regRdata(regRdata), .linkIn(linkIn),
        .transmitPin(transmitPin), .busClockEnable(busClockEnable), .stampWrite(stampWrite),
        .stampByteHi(stampByteHi), .stampValue(stampValue), .irq(irq));
    can_bus_node u_can_bus_node (.clk(clk), .frameGo(frameGo), .ackGo(ackGo), .rxLevel(rxLevel),
        .syncLevel(syncLevel), .frameOk(fOk), .ackDone(aDone), .rxActive(rxA), .synced(syn));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic void chk(string n, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e) begin
            nErrors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endfunction : chk
    task automatic finalReport;
        if (nErrors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finalReport
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regReq.addr <= a;
        regReq.wdata <= d;
        regReq.wr <= 1'b1;
        @(posedge clk);
        regReq.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        regReq.addr <= a;
        regReq.rd <= 1'b1;
        expQ.push_back(e);
        @(posedge clk);
        regReq.rd <= 1'b0;
    endtask : rd
    task automatic kick(input logic f, input logic a);
        @(posedge clk);
        frameGo <= f;
        ackGo <= a;
        @(posedge clk);
        frameGo <= 1'b0;
        ackGo <= 1'b0;
    endtask : kick
    always @(posedge clk) begin
        rdSeen <= regReq.rd;
        if (rdSeen && expQ.size() > 0) chk("regRdata", {8'h00, expQ.pop_front()}, {8'h00, regRdata});
    end
    initial begin
        repeat (20000) @(posedge clk);
        nErrors++;
        finalReport();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hd155_b97a));
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'h00, 8'h01);
        rd(8'h01, 8'h01);
        wr(8'h00, 8'h2D);
        rd(8'h00, 8'h05);
        wr(8'h00, 8'h00);
        repeat (3) @(posedge clk);
        wr(8'h00, 8'h01);
        repeat (3) @(posedge clk);
        rd(8'h02, 8'h02);
        rd(8'h01, 8'h01);
        wr(8'h00, 8'h00);
        repeat (3) @(posedge clk);
        rd(8'h01, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rx = 1'($urandom);
            sy = 1'($urandom);
            rxLevel <= rx;
            syncLevel <= sy;
            repeat (3) @(posedge clk);
            rd(8'h00, {1'b0, rx, 1'b0, sy, 4'h0});
        end
        rxLevel <= 1'b0;
        syncLevel <= 1'b0;
        wr(8'h03, 8'h01);
        kick(1'b1, 1'b0);
        repeat (3) @(posedge clk);
        chk("irq", 16'h0001, {15'h0, irq});
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h80);
        wr(8'h00, 8'h80);
        rd(8'h00, 8'h00);
        @(posedge clk);
        frameGo <= 1'b1;
        @(posedge clk);
        frameGo <= 1'b0;
        regReq.addr <= 8'h00;
        regReq.wdata <= 8'h80;
        regReq.wr <= 1'b1;
        @(posedge clk);
        regReq.wr <= 1'b0;
        rd(8'h00, 8'h80);
        rd(8'h02, 8'h01);
        repeat (2) @(posedge clk);
        chk("irq", 16'h0000, {15'h0, irq});
        wr(8'h03, 8'h00);
        kick(1'b1, 1'b0);
        repeat (3) @(posedge clk);
        chk("irq", 16'h0000, {15'h0, irq});
        rd(8'h02, 8'h01);
        wr(8'h00, 8'h80);
        wr(8'h00, 8'h08);
        repeat (12) @(posedge clk);
        kick(1'b0, 1'b1);
        repeat (3) @(posedge clk);
        chk("stampSet", 16'h0001, {15'h0, stampValue != 16'h0000});
        rd(8'h02, 8'h04);
        rd(8'h00, 8'h08);
        wr(8'h00, 8'h09);
        repeat (3) @(posedge clk);
        rd(8'h06, 8'h00);
        rd(8'h07, 8'h00);
        rd(8'h00, 8'h01);
        wr(8'h00, 8'h00);
        repeat (3) @(posedge clk);
        chk("transmitPin", 16'h0000, {15'h0, transmitPin});
        waitMode <= 1'b1;
        repeat (3) @(posedge clk);
        chk("busClockEnable", 16'h0001, {15'h0, busClockEnable});
        waitMode <= 1'b0;
        wr(8'h00, 8'h20);
        waitMode <= 1'b1;
        repeat (3) @(posedge clk);
        chk("busClockEnable", 16'h0000, {15'h0, busClockEnable});
        chk("transmitPin", 16'h0001, {15'h0, transmitPin});
        rd(8'h00, 8'h00);
        waitMode <= 1'b0;
        repeat (3) @(posedge clk);
        rd(8'h00, 8'h20);
        stopMode <= 1'b1;
        repeat (2) @(posedge clk);
        chk("transmitPin", 16'h0001, {15'h0, transmitPin});
        stopMode <= 1'b0;
        wr(8'h40, 8'hFF);
        rd(8'h40, 8'h00);
        repeat (3) @(posedge clk);
        finalReport();
    end
endmodule : can_control_zero_bench

// ---- can_control_zero_sva.sv ----
// checker: port-level properties of the control register 0 block
`timescale 1ns/1ps
module can_control_zero_sva #(
    parameter logic [15:0] BIT_DIV = 16'h0000
) (
    input wire logic                   clk,
    input wire logic                   arst_n,
    input wire can_ctl0_pkg::reg_req_t regReq,
    input wire logic [7:0]             regRdata,
    input wire can_ctl0_pkg::link_in_t linkIn,
    input wire logic                   transmitPin,
    input wire logic                   busClockEnable,
    input wire logic                   stampWrite,
    input wire logic [3:0]             stampByteHi,
    input wire logic [15:0]            stampValue,
    input wire logic                   irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_rdata_idle: assert property (!$past(regReq.rd) |-> regRdata == 8'h00)
        else $error("read data outside read answer");
    a_unmapped_zero: assert property ($past(regReq.rd && regReq.addr > 8'h07) |-> regRdata == 8'h00)
        else $error("unmapped read not zero");
    a_receiver_active_cause: assert property ($past(regReq.rd && regReq.addr == 8'h00) && regRdata[6]
        |-> $past(linkIn.rxActive) || $past(linkIn.rxActive, 2)) else $error("receiver bit without cause");
    a_sync_cause: assert property ($past(regReq.rd && regReq.addr == 8'h00) && regRdata[4]
        |-> $past(linkIn.synced) || $past(linkIn.synced, 2)) else $error("sync bit without cause");
    a_stamp_after_ack: assert property (stampWrite |-> $past(linkIn.ackDone))
        else $error("stamp write without acknowledge");
    a_stamp_hold: assert property ($changed(stampValue) |-> stampWrite)
        else $error("stamp value moved without write");
    a_stamp_index: assert property (stampByteHi == can_ctl0_pkg::STAMP_BYTE_HI)
        else $error("stamp byte index wrong");
    a_stop_recessive: assert property (linkIn.stopMode |=> transmitPin)
        else $error("transmit pin dominant in stop");
    a_no_wait_clock: assert property (!linkIn.waitMode |=> busClockEnable)
        else $error("bus clock gated outside wait");
    a_wait_recessive: assert property (linkIn.waitMode && !busClockEnable |=> transmitPin)
        else $error("transmit pin dominant in gated wait");
endmodule : can_control_zero_sva

bind can_control_zero can_control_zero_sva #(.BIT_DIV(BIT_DIV)) u_can_control_zero_sva (
    .clk(clk), .arst_n(arst_n), .regReq(regReq), .regRdata(regRdata), .linkIn(linkIn),
    .transmitPin(transmitPin), .busClockEnable(busClockEnable), .stampWrite(stampWrite),
    .stampByteHi(stampByteHi), .stampValue(stampValue), .irq(irq));

// ---- can_ctl0_pkg.sv ----
// package: register map, bit positions, reset values and types of the control register 0 block
package can_ctl0_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTL0_OFFSET     = 8'h00;
    localparam logic [7:0] CTL1_OFFSET     = 8'h01;
    localparam logic [7:0] IRQ_STAT_OFFSET = 8'h02;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h03;
    localparam logic [7:0] STAMP_LO_OFFSET = 8'h04;
    localparam logic [7:0] STAMP_HI_OFFSET = 8'h05;
    localparam logic [7:0] COUNT_LO_OFFSET = 8'h06;
    localparam logic [7:0] COUNT_HI_OFFSET = 8'h07;

    // ------------------------------------------------------------
    // control register 0 bit positions
    // ------------------------------------------------------------
    localparam int RX_FRAME_BIT   = 7;
    localparam int RX_ACTIVE_BIT  = 6;
    localparam int STOP_WAIT_BIT  = 5;
    localparam int SYNC_BIT       = 4;
    localparam int TIMER_EN_BIT   = 3;
    localparam int WAKEUP_EN_BIT  = 2;
    localparam int SLEEP_REQ_BIT  = 1;
    localparam int INIT_REQ_BIT   = 0;
    // control register 1: init acknowledge in bit 0
    localparam int INIT_ACK_BIT   = 0;

    // interrupt status / mask bit positions
    localparam int IRQ_FRAME_BIT  = 0;
    localparam int IRQ_INIT_BIT   = 1;
    localparam int IRQ_STAMP_BIT  = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  CTL0_RESET     = 8'h01;
    localparam logic [2:0]  IRQ_RESET      = 3'h0;
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [15:0] BIT_DIV_RESET  = 16'h0000;

    // timestamp goes to the two highest bytes of a buffer
    localparam logic [3:0]  STAMP_BYTE_HI  = 4'hF;
    localparam logic [3:0]  STAMP_BYTE_LO  = 4'hE;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic       frameOk;
        logic       rxActive;
        logic       synced;
        logic       ackDone;
        logic       waitMode;
        logic       stopMode;
        logic       txBit;
    } link_in_t;

endpackage : can_ctl0_pkg
